// ---- verilog/stm_consts.svh ----
// Register offsets, function codes, reset values and timing counts for the torque monitor
`ifndef STM_CONSTS_SVH
`define STM_CONSTS_SVH

`define STM_CLK_HZ 100000000
`define STM_TICK_US 1000
`define STM_TICK_CYC ((`STM_CLK_HZ / 1000000) * `STM_TICK_US)
`define STM_STALL_MS 100
`define STM_STALL_TICKS (`STM_STALL_MS * 1000 / `STM_TICK_US)
`define STM_STALL_HYST_PCT 10'h002
`define STM_TQ_HYST_PCT 10'h00A

`define STM_ADDR_CTRL 8'h00
`define STM_ADDR_STALL 8'h04
`define STM_ADDR_DET1 8'h08
`define STM_ADDR_DET2 8'h0C
`define STM_ADDR_OUTSEL 8'h10
`define STM_ADDR_STATUS 8'h14
`define STM_ADDR_IRQ_STAT 8'h18
`define STM_ADDR_IRQ_MASK 8'h1C
`define STM_ADDR_FEED 8'h20

`define STM_RST_STALL_EN 1'b1
`define STM_RST_STALL_LVL 10'h096
`define STM_RST_MODE1 4'h2
`define STM_RST_MODE2 4'h0
`define STM_RST_LVL 10'h096
`define STM_RST_TIME1 16'h0064
`define STM_RST_TIME2 16'h0001
`define STM_FC_DET1_NO 8'h0B
`define STM_FC_DET1_NC 8'h17
`define STM_FC_DET2_NO 8'h18
`define STM_FC_DET2_NC 8'h19
`define STM_RST_OUTSEL 8'h0F

`endif

// ---- verilog/stm_pkg.sv ----
// Types shared by the torque monitor modules
package stm_pkg;
	typedef enum logic [1:0] {
		STM_VF,
		STM_OLV,
		STM_CLV
	} stm_ctrl_e;

	typedef struct packed {
		logic [3:0] mode;
		logic [9:0] level;
		logic [15:0] time_ds;
	} stm_det_cfg_s;

	typedef struct packed {
		logic active;
		logic over;
		logic stop;
	} stm_det_out_s;
endpackage

// ---- verilog/stm_det.sv ----
// One overtorque or undertorque detector with duration timer and release band
`timescale 1ns/10ps
`include "stm_consts.svh"
module stm_det
	import stm_pkg::*;
#(
	parameter int TW = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick,
	input wire logic running,
	input wire logic speed_agree,
	input wire logic [9:0] value,
	input stm_det_cfg_s cfg,
	output stm_det_out_s det
);
	logic over_mode;
	logic agree_only;
	logic enabled;
	logic gate;
	logic beyond;
	logic back;
	logic [TW-1:0] cnt_r;
	logic [9:0] rel_lvl;

	assign enabled = (cfg.mode != 4'h0) && (cfg.mode <= 4'h8);
	assign over_mode = (cfg.mode <= 4'h4);
	assign agree_only = cfg.mode[0];
	assign gate = enabled && running && (!agree_only || speed_agree);
	assign beyond = over_mode ? (value > cfg.level) : (value < cfg.level);
	// Release only after the value crosses back by the band
	assign rel_lvl = over_mode ? ((cfg.level > `STM_TQ_HYST_PCT) ?
		cfg.level - `STM_TQ_HYST_PCT : 10'h000) : cfg.level + `STM_TQ_HYST_PCT;
	assign back = over_mode ? (value < rel_lvl) : (value > rel_lvl);

	// Timer counts in tenths of a second; clears as soon as the condition lapses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else if (!gate || !beyond) begin
			cnt_r <= '0;
		end else if (tick && cnt_r != {TW{1'b1}}) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			det <= '0;
		end else if (!gate || (det.active && back)) begin
			det <= '0;
		end else if (!det.active && beyond && cnt_r >= cfg.time_ds) begin
			det.active <= 1'b1;
			det.over <= over_mode;
			det.stop <= cfg.mode[1] ^ cfg.mode[0] ? 1'b0 : 1'b0 | (cfg.mode == 4'h3) |
				(cfg.mode == 4'h4) | (cfg.mode == 4'h7) | (cfg.mode == 4'h8);
		end
	end
endmodule

// ---- verilog/stm_stall.sv ----
// Stall prevention comparator, 100 ms qualification and 2 % release
`timescale 1ns/10ps
`include "stm_consts.svh"
module stm_stall
	import stm_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic tick_ms,
	input wire logic enable,
	input wire logic [9:0] current,
	input wire logic [9:0] level,
	output logic reducing
);
	logic [7:0] cnt_r;
	logic [9:0] rel_lvl;

	assign rel_lvl = (level > `STM_STALL_HYST_PCT) ? level - `STM_STALL_HYST_PCT : 10'h000;

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable || current <= level) begin
			cnt_r <= 8'h00;
		end else if (tick_ms && cnt_r != 8'hFF) begin
			cnt_r <= cnt_r + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !enable) begin
			reducing <= 1'b0;
		end else if (reducing && current <= rel_lvl) begin
			reducing <= 1'b0;
		end else if (cnt_r >= 8'(`STM_STALL_TICKS)) begin
			reducing <= 1'b1;
		end
	end
endmodule

// ---- verilog/stm_top.sv ----
// Stall and torque monitor with AXI4-Lite register access
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "stm_consts.svh"

// Behaviour
// - Start speed reduction after current exceeds stall level for 100 ms.
// - Reaccelerate when current falls to stall level minus two percent.
// - Stall prevention only in V/f control, enabled by select, default 1.
// - Reduction decelerates using first or second deceleration time setting.
// - Stall level is percent of rated current, default 150.
// - Compare current in V/f, torque reference in vector modes.
// - First detector: level 150 percent, time 10.0 s defaults.
// - Second detector: level 150 percent, time 0.1 s defaults.
// - Mode select resets to 2 for first, 0 for second.
// - Code B closes output while first detector reports.
// - Code 17 opens output while first detector reports.
// - Codes 18 and 19 map second detector open and closed sense.
// - Three contact outputs, each with own function code.
// - Mode: 0 off, 1-4 over, 5-8 under, odd agree, 3478 stop.
// - Release after value crosses back by ten percent band.
module stm_top
	import stm_pkg::*;
#(
	parameter int TICK_CYC = `STM_TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] output_current,
	input wire logic [9:0] torque_reference,
	input wire logic [1:0] control_method,
	input wire logic running,
	input wire logic speed_agree,
	output logic [2:0] contact_output_terminal_pair,
	output logic stall_reduce,
	output logic decel_select_second,
	output logic output_stop,
	output logic irq
);
	logic stall_enable_select_r;
	logic decel_sel_r;
	logic [9:0] stall_current_level_r;
	stm_det_cfg_s cfg1_r;
	stm_det_cfg_s cfg2_r;
	logic [7:0] contact_output_function_select_r [3];
	logic [3:0] irq_stat_r;
	logic [3:0] irq_mask_r;
	// Wide enough for the full tick count at the real clock rate
	localparam int TCW = $clog2(TICK_CYC + 1);
	logic [TCW-1:0] tick_cnt_r;
	logic tick_ms_r;
	logic [6:0] ds_cnt_r;
	logic tick_ds_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic stall_red;
	logic [9:0] tq_value;
	stm_det_out_s det1;
	stm_det_out_s det2;
	stm_det_out_s det1_d_r;
	stm_det_out_s det2_d_r;
	logic [3:0] events;
	logic do_write;
	logic do_read;
	logic [31:0] rd_word;
	logic [31:0] wr_old;
	logic [31:0] wr_word;

	function automatic logic contact_state(input logic [7:0] fc, input logic d1, input logic d2);
		case (fc)
			`STM_FC_DET1_NO: contact_state = d1;
			`STM_FC_DET1_NC: contact_state = !d1;
			`STM_FC_DET2_NO: contact_state = d2;
			`STM_FC_DET2_NC: contact_state = !d2;
			default: contact_state = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		merge = res;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Sample ticks: 1 ms for stall, 0.1 s for torque timers
	always_ff @(posedge aclk) begin
		if (!aresetn || tick_cnt_r == TCW'(TICK_CYC - 1)) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_ms_r <= 1'b0;
		end else begin
			tick_ms_r <= (tick_cnt_r == TCW'(TICK_CYC - 1));
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ds_cnt_r <= 7'h00;
			tick_ds_r <= 1'b0;
		end else begin
			tick_ds_r <= tick_ms_r && ds_cnt_r == 7'h63;
			if (tick_ms_r) begin
				ds_cnt_r <= (ds_cnt_r == 7'h63) ? 7'h00 : ds_cnt_r + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Monitors
	assign tq_value = (control_method == STM_VF) ? output_current : torque_reference;

	stm_stall u_stall (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick_ms(tick_ms_r),
		.enable(stall_enable_select_r && control_method == STM_VF && running),
		.current(output_current),
		.level(stall_current_level_r),
		.reducing(stall_red)
	);

	stm_det #(.TW(16)) u_det1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick_ds_r),
		.running(running),
		.speed_agree(speed_agree),
		.value(tq_value),
		.cfg(cfg1_r),
		.det(det1)
	);

	stm_det #(.TW(16)) u_det2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.tick(tick_ds_r),
		.running(running),
		.speed_agree(speed_agree),
		.value(tq_value),
		.cfg(cfg2_r),
		.det(det2)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			contact_output_terminal_pair <= 3'b000;
			stall_reduce <= 1'b0;
			decel_select_second <= 1'b0;
			output_stop <= 1'b0;
			det1_d_r <= '0;
			det2_d_r <= '0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				contact_output_terminal_pair[i] <= contact_state(
					contact_output_function_select_r[i], det1.active, det2.active);
			end
			stall_reduce <= stall_red;
			decel_select_second <= decel_sel_r;
			output_stop <= (det1.active && det1.stop) || (det2.active && det2.stop);
			det1_d_r <= det1;
			det2_d_r <= det2;
		end
	end

	// Events: over/under alarm first and second, rising edges only
	assign events = {det2.active && !det2_d_r.active && !det2.over,
		det1.active && !det1_d_r.active && !det1.over,
		det2.active && !det2_d_r.active && det2.over,
		det1.active && !det1_d_r.active && det1.over};

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave: address and data accepted in either order
	assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
	assign do_read = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_r > `STM_ADDR_FEED || aw_addr_r[1:0] != 2'b00 ||
					aw_addr_r == `STM_ADDR_STATUS || aw_addr_r == `STM_ADDR_IRQ_STAT ||
					aw_addr_r == `STM_ADDR_FEED) ? 2'b10 : 2'b00;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Old word of the addressed register, so a partial strobe keeps the other bytes
	always_comb begin
		case (aw_addr_r)
			`STM_ADDR_CTRL: wr_old = {30'h0, decel_sel_r, stall_enable_select_r};
			`STM_ADDR_STALL: wr_old = {22'h0, stall_current_level_r};
			`STM_ADDR_DET1: wr_old = {2'b00, cfg1_r};
			`STM_ADDR_DET2: wr_old = {2'b00, cfg2_r};
			default: wr_old = 32'h00000000;
		endcase
	end

	assign wr_word = merge(wr_old, w_data_r, w_strb_r);

	// Configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stall_enable_select_r <= `STM_RST_STALL_EN;
			decel_sel_r <= 1'b0;
			stall_current_level_r <= `STM_RST_STALL_LVL;
			cfg1_r <= '{`STM_RST_MODE1, `STM_RST_LVL, `STM_RST_TIME1};
			cfg2_r <= '{`STM_RST_MODE2, `STM_RST_LVL, `STM_RST_TIME2};
			irq_mask_r <= 4'h0;
			for (int i = 0; i < 3; i++) begin
				contact_output_function_select_r[i] <= `STM_RST_OUTSEL;
			end
		end else if (do_write) begin
			case (aw_addr_r)
				`STM_ADDR_CTRL: {decel_sel_r, stall_enable_select_r} <= wr_word[1:0];
				`STM_ADDR_STALL: stall_current_level_r <= wr_word[9:0];
				`STM_ADDR_DET1: cfg1_r <= wr_word[29:0];
				`STM_ADDR_DET2: cfg2_r <= wr_word[29:0];
				`STM_ADDR_OUTSEL: begin
					for (int i = 0; i < 3; i++) begin
						if (w_strb_r[i]) begin
							contact_output_function_select_r[i] <= w_data_r[i*8 +: 8];
						end
					end
				end
				`STM_ADDR_IRQ_MASK: irq_mask_r <= w_strb_r[0] ? w_data_r[3:0] : irq_mask_r;
				default: ;
			endcase
		end
	end

	// Sticky status, cleared by read; a new event in the read cycle survives
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 4'h0;
		end else if (do_read && s_axi_araddr == `STM_ADDR_IRQ_STAT) begin
			irq_stat_r <= events;
		end else begin
			irq_stat_r <= irq_stat_r | events;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irq_stat_r | events) & irq_mask_r);
		end
	end

	always_comb begin
		rd_word = 32'h00000000;
		case (s_axi_araddr)
			`STM_ADDR_CTRL: rd_word = {30'h0, decel_sel_r, stall_enable_select_r};
			`STM_ADDR_STALL: rd_word = {22'h0, stall_current_level_r};
			`STM_ADDR_DET1: rd_word = {2'b00, cfg1_r};
			`STM_ADDR_DET2: rd_word = {2'b00, cfg2_r};
			`STM_ADDR_OUTSEL: rd_word = {8'h00, contact_output_function_select_r[2],
				contact_output_function_select_r[1], contact_output_function_select_r[0]};
			`STM_ADDR_STATUS: rd_word = {24'h0, stall_red, det2.stop, det2.over, det2.active,
				det1.stop, det1.over, det1.active, output_stop};
			`STM_ADDR_IRQ_STAT: rd_word = {28'h0, irq_stat_r};
			`STM_ADDR_IRQ_MASK: rd_word = {28'h0, irq_mask_r};
			`STM_ADDR_FEED: rd_word = {6'h00, tq_value, 6'h00, output_current};
			default: rd_word = 32'h00000000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (do_read) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (s_axi_araddr > `STM_ADDR_FEED || s_axi_araddr[1:0] != 2'b00) ?
					2'b10 : 2'b00;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ---- verif/stm_checker.sv ----
// Port-level assertions for the stall and torque monitor
`timescale 1ns/10ps
module stm_checker
	import stm_pkg::*;
#(
	parameter int TICK_CYC = 10
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] output_current,
	input wire logic [1:0] control_method,
	input wire logic running,
	input wire logic [2:0] contact_output_terminal_pair,
	input wire logic stall_reduce,
	input wire logic decel_select_second,
	input wire logic output_stop
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic [31:0] cnt_r;
	logic [9:0] cur_r;
	logic wf;
	assign wf = s_axi_wvalid && s_axi_wready;
	// Cycles the current has held one value in V/f control
	always_ff @(posedge aclk) begin
		cur_r <= output_current;
		if (!aresetn || control_method != 2'h0 || output_current != cur_r) begin
			cnt_r <= 32'h00000000;
		end else if (cnt_r != 32'hFFFFFFFF) begin
			cnt_r <= cnt_r + 32'h00000001;
		end
	end
	stall_qual_a: assert property ($rose(stall_reduce) |-> cnt_r >= 99 * TICK_CYC)
		else $error("stall reduction came too early");
	stall_vf_a: assert property ($rose(stall_reduce) |-> $past(control_method) == 2'h0)
		else $error("stall reduction outside V/f control");
	decel_sel_a: assert property ($changed(decel_select_second) |->
		$past(wf) || $past(wf, 2) || $past(wf, 3) || $past(wf, 4))
		else $error("decel select moved without a write");
	stop_run_a: assert property ($rose(output_stop) |-> $past(running))
		else $error("output stop while not running");
	reset_quiet_a: assert property ($rose(aresetn) |-> !stall_reduce && !output_stop
		&& !decel_select_second && contact_output_terminal_pair == 3'h0)
		else $error("outputs not quiet after reset");
	read_ans_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("address ready longer than one cycle");
endmodule
bind stm_top stm_checker #(.TICK_CYC(TICK_CYC)) chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.output_current(output_current), .control_method(control_method), .running(running),
	.contact_output_terminal_pair(contact_output_terminal_pair), .stall_reduce(stall_reduce),
	.decel_select_second(decel_select_second), .output_stop(output_stop));

// ---- verif/stm_core_model.sv ----
// Behavioural motor-control core feeding current, torque and run status
`timescale 1ns/10ps
module stm_core_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [9:0] cur_set,
	input wire logic [9:0] tq_set,
	input wire logic [1:0] meth_set,
	input wire logic run_set,
	input wire logic agree_set,
	output logic [9:0] current,
	output logic [9:0] torque,
	output logic [1:0] method,
	output logic running,
	output logic agree
);
	// A stopped motor draws no current and makes no torque
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			current <= 10'h000;
			torque <= 10'h000;
			method <= 2'h0;
			running <= 1'b0;
			agree <= 1'b0;
		end else begin
			current <= run_set ? cur_set : 10'h000;
			torque <= run_set ? tq_set : 10'h000;
			method <= meth_set;
			running <= run_set;
			agree <= run_set && agree_set;
		end
	end
endmodule

// ---- verif/stm_top_test.sv ----
// Self-checking bench for the stall and torque monitor
`timescale 1ns/10ps
`include "stm_consts.svh"
module stm_top_test
	import stm_pkg::*;
;
	localparam int TC = 10;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, run, agree, running, agreed, sred, dsel, ostop, irq;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, meth, method;
	logic [9:0] cur, tq, current, torque;
	logic [2:0] cop;
	int err_count, total_checks, cyc;
	stm_core_model core_u (.aclk(aclk), .aresetn(aresetn), .cur_set(cur), .tq_set(tq),
		.meth_set(meth), .run_set(run), .agree_set(agree), .current(current), .torque(torque),
		.method(method), .running(running), .agree(agreed));
	stm_top #(.TICK_CYC(TC)) dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.output_current(current), .torque_reference(torque), .control_method(method),
		.running(running), .speed_agree(agreed), .contact_output_terminal_pair(cop),
		.stall_reduce(sred), .decel_select_second(dsel), .output_stop(ostop), .irq(irq));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task print_verdict;
		$display("checks=%0d errors=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	task drive(input logic [9:0] c, input logic [9:0] t, input logic [1:0] m, input int n);
		@(posedge aclk);
		cur <= c;
		tq <= t;
		meth <= m;
		repeat (n) @(posedge aclk);
	endtask
	// Bounded wait; the following compare judges the outcome
	task wcop(input logic [2:0] e, input int n);
		for (int i = 0; i < n && cop !== e; i++) @(posedge aclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdr(`STM_ADDR_CTRL);
		chk(rd[1:0], 2'h1);
		rdr(`STM_ADDR_STALL);
		chk(rd, 32'h00000096);
		rdr(`STM_ADDR_DET1);
		chk(rd, 32'h08960064);
		rdr(`STM_ADDR_DET2);
		chk(rd, 32'h00960001);
		rdr(`STM_ADDR_OUTSEL);
		chk(rd[7:0], 8'h0F);
		chk(cop, 3'h0);
		$display("reset test done");
	endtask
	task t_axi;
		wr(`STM_ADDR_STATUS, 32'h0000FFFF);
		chk(rs, 2'h2);
		rdr(8'h24);
		chk(rs, 2'h2);
		chk(rd, 32'h0);
		$display("bus test done");
	endtask
	task t_stall;
		wr(`STM_ADDR_CTRL, 32'h1);
		drive(10'h0A0, 10'h000, 2'h0, 900);
		chk(sred, 1'b0);
		for (int i = 0; i < 300 && sred !== 1'b1; i++) @(posedge aclk);
		chk(sred, 1'b1);
		drive(10'h095, 10'h000, 2'h0, 20);
		chk(sred, 1'b1);
		drive(10'h094, 10'h000, 2'h0, 20);
		chk(sred, 1'b0);
		// Select output is registered one edge after the register itself
		wr(`STM_ADDR_CTRL, 32'h3);
		@(posedge aclk);
		chk(dsel, 1'b1);
		wr(`STM_ADDR_CTRL, 32'h1);
		@(posedge aclk);
		chk(dsel, 1'b0);
		// A short dip must restart the 100 ms qualification
		drive(10'h0A0, 10'h000, 2'h0, 600);
		drive(10'h064, 10'h000, 2'h0, 20);
		drive(10'h0A0, 10'h000, 2'h0, 600);
		chk(sred, 1'b0);
		drive(10'h064, 10'h000, 2'h0, 0);
		$display("stall test done");
	endtask
	task t_stall_off;
		wr(`STM_ADDR_CTRL, 32'h0);
		drive(10'h0A0, 10'h000, 2'h0, 1200);
		chk(sred, 1'b0);
		drive(10'h064, 10'h000, 2'h1, 0);
		wr(`STM_ADDR_CTRL, 32'h1);
		drive(10'h0A0, 10'h000, 2'h1, 1200);
		chk(sred, 1'b0);
		drive(10'h064, 10'h000, 2'h0, 0);
		$display("stall off test done");
	endtask
	task t_det1;
		wr(`STM_ADDR_OUTSEL, 32'h000F170B);
		wr(`STM_ADDR_DET1, 32'h08960003);
		wr(`STM_ADDR_IRQ_MASK, 32'h1);
		chk(cop, 3'h2);
		drive(10'h0A0, 10'h000, 2'h0, 1500);
		chk(cop, 3'h2);
		// Tick phase is free running, so allow a full extra tenth
		wcop(3'h1, 2500);
		chk(cop, 3'h1);
		chk(ostop, 1'b0);
		chk(irq, 1'b1);
		rdr(`STM_ADDR_IRQ_STAT);
		chk(rd[0], 1'b1);
		rdr(`STM_ADDR_IRQ_STAT);
		chk(rd[0], 1'b0);
		chk(irq, 1'b0);
		drive(10'h091, 10'h000, 2'h0, 20);
		chk(cop, 3'h1);
		drive(10'h082, 10'h000, 2'h0, 20);
		chk(cop, 3'h2);
		wr(`STM_ADDR_IRQ_MASK, 32'h0);
		$display("detector one test done");
	endtask
	task t_det2;
		wr(`STM_ADDR_OUTSEL, 32'h0018190F);
		wr(`STM_ADDR_DET2, 32'h20640003);
		drive(10'h014, 10'h096, 2'h2, 1200);
		chk(cop, 3'h2);
		drive(10'h014, 10'h032, 2'h2, 1500);
		drive(10'h014, 10'h096, 2'h2, 20);
		drive(10'h014, 10'h032, 2'h2, 1500);
		chk(cop, 3'h2);
		wcop(3'h4, 2500);
		chk(cop, 3'h4);
		chk(ostop, 1'b1);
		drive(10'h014, 10'h069, 2'h2, 20);
		chk(cop, 3'h4);
		drive(10'h014, 10'h078, 2'h2, 20);
		chk(cop, 3'h2);
		chk(ostop, 1'b0);
		wr(`STM_ADDR_DET2, 32'h1C640003);
		drive(10'h014, 10'h032, 2'h2, 2500);
		chk(cop, 3'h2);
		agree <= 1'b1;
		wcop(3'h4, 3300);
		chk(cop, 3'h4);
		wr(`STM_ADDR_DET2, 32'h00640003);
		repeat (4) @(posedge aclk);
		chk(cop, 3'h2);
		$display("detector two test done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 40000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, agree} = 6'h00;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		{cur, tq, meth} = 22'h0;
		run = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_axi;
		t_stall;
		t_stall_off;
		t_det1;
		t_det2;
		print_verdict;
	end
endmodule
